// *** rtl/mmcd_top.sv ***
// motion command decoder: apb register access, command execution, replies
// Contract
// - read global param loads the accumulator
// - read reply: status 100 with value
// - frame: addr, instr, type, bank, value, sum
// - store writes user variable to nvm
// - bank 0 changes commit to nvm
// - user variables reload after power-up
// - restore reloads user variable from nvm
// - home search: 13, type start/stop/status
// - status query: value nonzero while searching
// - start/stop reply status 100
// - start launches, stop halts, status reads
// - set output drives line, replies 100
// - banks: 0 module, 2 user, 3 irq
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module mmcd_top (
	input  wire logic        clk,       // system clock, 250 MHz
	input  wire logic        rst_n,     // sync reset, active low
	input  wire logic        ce,        // clock enable, freezes all state
	input  wire logic        psel,      // apb select
	input  wire logic        penable,   // apb enable
	input  wire logic        pwrite,    // apb direction
	input  wire logic [7:0]  paddr,     // apb byte address
	input  wire logic [31:0] pwdata,    // apb write data
	output logic      [31:0] prdata,    // apb read data
	output logic             pready,    // apb ready
	output logic             pslverr,   // apb error
	input  wire logic        home_sw,   // home switch pin
	output logic             home_busy, // home search running
	output logic      [1:0]  gp_out,    // general purpose outputs
	output logic             nvm_req,   // nvm request, held to ack
	output logic             nvm_we,    // nvm write
	output logic [mmcd_pkg::NVM_AW-1:0] nvm_addr, // nvm word address
	output logic      [31:0] nvm_wdata, // nvm write data
	input  wire logic [31:0] nvm_rdata, // nvm read data, valid with ack
	input  wire logic        nvm_ack    // nvm done, one cycle
);
	mmcd_frame_if fr ();
	mmcd_pkg::mmcd_state_e state_r;
	logic [31:0] accum_r;
	logic [31:0] uvar_r [mmcd_pkg::NUM_UVARS];
	logic [31:0] irqcfg_r [8];
	logic [7:0]  mod_addr_r;
	logic        rply_vld_r;
	logic [7:0]  rply_stat_r;
	logic [7:0]  rply_ins_r;
	logic [31:0] rply_val_r;
	logic        home_r;
	logic [1:0]  gp_out_r;
	logic        nvm_req_r;
	logic        nvm_we_r;
	logic [mmcd_pkg::NVM_AW-1:0] nvm_addr_r;
	logic [31:0] nvm_wdata_r;
	logic [7:0]  pend_ins_r;
	logic [7:0]  pend_idx_r;
	logic [7:0]  boot_idx_r;
	logic        hsw_s1_r;
	logic        hsw_s2_r;
	logic        hsw_d_r;
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;
	logic [7:0]  dec_stat;
	logic [31:0] dec_val;
	logic        dec_nvm;
	logic [1:0]  sio_all;
	logic        exec;
	logic        ok;
	logic        nvm_done;
	logic        busy;
	logic        wr_fire;
	logic        rd_err;
	logic [31:0] rd_mux;
	logic [7:0]  rply_sum;

	mmcd_frame_rx u_rx (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.fr    (fr)
	);

	// handshake terms
	assign busy     = state_r != mmcd_pkg::ST_IDLE;
	assign exec     = ce && state_r == mmcd_pkg::ST_IDLE && fr.frm_vld;
	assign ok       = dec_stat == mmcd_pkg::STAT_OK;
	assign nvm_done = nvm_req_r && nvm_ack;
	assign sio_all  = (fr.value == mmcd_pkg::VAL_FROM_ACCUM) ? accum_r[1:0] : fr.value[1:0];

	// decode one frame; anything not understood gets an error code
	always_comb begin
		dec_stat = mmcd_pkg::ERR_INSTR;
		dec_val  = 32'h00000000;
		dec_nvm  = 1'b0;
		case (fr.instr)
			mmcd_pkg::INS_READ_GLOBAL_PARAM, mmcd_pkg::INS_WRITE_GLOBAL_PARAM: begin
				dec_stat = mmcd_pkg::STAT_OK;
				if (fr.bank == mmcd_pkg::BANK_MODULE && fr.typ == mmcd_pkg::PARAM_MOD_ADDR) begin
					dec_val = {24'h000000, mod_addr_r};
					dec_nvm = fr.instr == mmcd_pkg::INS_WRITE_GLOBAL_PARAM;
				end else if (fr.bank == mmcd_pkg::BANK_USER) begin
					dec_val = uvar_r[fr.typ];
				end else if (fr.bank == mmcd_pkg::BANK_IRQ && fr.typ < mmcd_pkg::NUM_IRQCFG) begin
					dec_val = irqcfg_r[fr.typ[2:0]];
				end else begin
					dec_stat = mmcd_pkg::ERR_TYPE;
				end
			end
			mmcd_pkg::INS_STORE_GLOBAL_PARAM, mmcd_pkg::INS_RESTORE_GLOBAL_PRM: begin
				dec_stat = (fr.bank == mmcd_pkg::BANK_USER) ? mmcd_pkg::STAT_OK
					: mmcd_pkg::ERR_TYPE;
				dec_nvm  = 1'b1;
			end
			mmcd_pkg::INS_HOME_SEARCH: begin
				// motor field must be zero on a single axis
				if (fr.bank != 8'h00 || fr.typ > mmcd_pkg::HS_STATUS) begin
					dec_stat = mmcd_pkg::ERR_TYPE;
				end else begin
					dec_stat = mmcd_pkg::STAT_OK;
					if (fr.typ == mmcd_pkg::HS_STATUS) begin
						dec_val = {31'h00000000, home_r};
					end
				end
			end
			mmcd_pkg::INS_SET_OUTPUT: begin
				if (fr.bank != mmcd_pkg::BANK_USER) begin
					dec_stat = mmcd_pkg::ERR_TYPE;
				end else if (fr.typ < mmcd_pkg::NUM_OUTS) begin
					dec_stat = (fr.value[31:1] == 31'h00000000) ? mmcd_pkg::STAT_OK
						: mmcd_pkg::ERR_VALUE;
				end else if (fr.typ == mmcd_pkg::SIO_ALL) begin
					dec_stat = (fr.value <= mmcd_pkg::SIO_ALL_MAX
						|| fr.value == mmcd_pkg::VAL_FROM_ACCUM) ? mmcd_pkg::STAT_OK
						: mmcd_pkg::ERR_VALUE;
				end else begin
					dec_stat = mmcd_pkg::ERR_TYPE;
				end
			end
			default: begin
				dec_stat = mmcd_pkg::ERR_INSTR;
			end
		endcase
	end

	// sequencer: reload all user variables first, then serve frames
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r    <= mmcd_pkg::ST_BOOT;
			boot_idx_r <= 8'h00;
		end else if (ce) begin
			unique case (state_r)
				mmcd_pkg::ST_BOOT: begin
					if (nvm_done) begin
						boot_idx_r <= 8'(boot_idx_r + 8'h01);
						if (boot_idx_r == mmcd_pkg::LAST_UVAR) begin
							state_r <= mmcd_pkg::ST_IDLE;
						end
					end
				end
				mmcd_pkg::ST_IDLE: begin
					if (exec && ok && dec_nvm) begin
						state_r <= mmcd_pkg::ST_NVM;
					end
				end
				mmcd_pkg::ST_NVM: begin
					if (nvm_done) begin
						state_r <= mmcd_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// nvm port: request stays up until the store acknowledges it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			nvm_req_r   <= 1'b0;
			nvm_we_r    <= 1'b0;
			nvm_addr_r  <= '0;
			nvm_wdata_r <= 32'h00000000;
			pend_ins_r  <= 8'h00;
			pend_idx_r  <= 8'h00;
		end else if (ce) begin
			if (nvm_done) begin
				nvm_req_r <= 1'b0;
			end else if (state_r == mmcd_pkg::ST_BOOT && !nvm_req_r) begin
				nvm_req_r  <= 1'b1;
				nvm_we_r   <= 1'b0;
				nvm_addr_r <= {mmcd_pkg::NVM_SEL_USER, boot_idx_r};
			end else if (exec && ok && dec_nvm) begin
				nvm_req_r   <= 1'b1;
				nvm_we_r    <= fr.instr != mmcd_pkg::INS_RESTORE_GLOBAL_PRM;
				nvm_addr_r  <= {(fr.bank == mmcd_pkg::BANK_USER), fr.typ};
				nvm_wdata_r <= (fr.bank == mmcd_pkg::BANK_USER) ? uvar_r[fr.typ] : fr.value;
				pend_ins_r  <= fr.instr;
				pend_idx_r  <= fr.typ;
			end
		end
	end

	// user variables: boot reload, restore, and direct writes
	always_ff @(posedge clk) begin
		if (ce) begin
			if (state_r == mmcd_pkg::ST_BOOT && nvm_done) begin
				uvar_r[boot_idx_r] <= nvm_rdata;
			end else if (state_r == mmcd_pkg::ST_NVM && nvm_done
				&& pend_ins_r == mmcd_pkg::INS_RESTORE_GLOBAL_PRM) begin
				uvar_r[pend_idx_r] <= nvm_rdata;
			end else if (exec && ok && fr.instr == mmcd_pkg::INS_WRITE_GLOBAL_PARAM
				&& fr.bank == mmcd_pkg::BANK_USER) begin
				uvar_r[fr.typ] <= fr.value;
			end
		end
	end

	// module settings and interrupt configuration
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mod_addr_r <= mmcd_pkg::MOD_ADDR_RST;
			accum_r    <= 32'h00000000;
			for (int i = 0; i < 8; i++) begin
				irqcfg_r[i] <= 32'h00000000;
			end
		end else if (exec && ok) begin
			if (fr.instr == mmcd_pkg::INS_READ_GLOBAL_PARAM) begin
				accum_r <= dec_val;
			end
			if (fr.instr == mmcd_pkg::INS_WRITE_GLOBAL_PARAM) begin
				if (fr.bank == mmcd_pkg::BANK_MODULE) begin
					mod_addr_r <= fr.value[7:0];
				end else if (fr.bank == mmcd_pkg::BANK_IRQ) begin
					irqcfg_r[fr.typ[2:0]] <= fr.value;
				end
			end
		end
	end

	// home switch pin: two flops before the edge detector
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hsw_s1_r <= 1'b0;
			hsw_s2_r <= 1'b0;
			hsw_d_r  <= 1'b0;
		end else if (ce) begin
			hsw_s1_r <= home_sw;
			hsw_s2_r <= hsw_s1_r;
			hsw_d_r  <= hsw_s2_r;
		end
	end

	// home search runs until stopped or the switch is reached
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			home_r <= 1'b0;
		end else if (ce) begin
			if (exec && ok && fr.instr == mmcd_pkg::INS_HOME_SEARCH
				&& fr.typ != mmcd_pkg::HS_STATUS) begin
				home_r <= fr.typ == mmcd_pkg::HS_START;
			end else if (hsw_s2_r && !hsw_d_r) begin
				home_r <= 1'b0;
			end
		end
	end

	// general purpose outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gp_out_r <= 2'h0;
		end else if (exec && ok && fr.instr == mmcd_pkg::INS_SET_OUTPUT) begin
			if (fr.typ == mmcd_pkg::SIO_ALL) begin
				gp_out_r <= sio_all;
			end else begin
				gp_out_r[fr.typ[0]] <= fr.value[0];
			end
		end
	end

	// reply latch; a new reply wins over a software clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rply_vld_r  <= 1'b0;
			rply_stat_r <= 8'h00;
			rply_ins_r  <= 8'h00;
			rply_val_r  <= 32'h00000000;
		end else if (ce) begin
			if (exec && !(ok && dec_nvm)) begin
				rply_vld_r  <= 1'b1;
				rply_stat_r <= dec_stat;
				rply_ins_r  <= fr.instr;
				rply_val_r  <= dec_val;
			end else if (state_r == mmcd_pkg::ST_NVM && nvm_done) begin
				rply_vld_r  <= 1'b1;
				rply_stat_r <= mmcd_pkg::STAT_OK;
				rply_ins_r  <= pend_ins_r;
				rply_val_r  <= 32'h00000000;
			end else if (wr_fire && paddr == mmcd_pkg::ADDR_CTRL
				&& pwdata[mmcd_pkg::CTRL_RPLY_BIT]) begin
				rply_vld_r <= 1'b0;
			end
		end
	end

	// reply checksum covers the eight bytes ahead of it
	assign rply_sum = 8'(mmcd_pkg::HOST_ADDR + mod_addr_r + rply_stat_r + rply_ins_r
		+ rply_val_r[31:24] + rply_val_r[23:16] + rply_val_r[15:8] + rply_val_r[7:0]);

	// apb read mux and error terms
	always_comb begin
		rd_mux = 32'h00000000;
		rd_err = 1'b0;
		case (paddr)
			mmcd_pkg::ADDR_RXDATA: rd_err = pwrite && busy;
			mmcd_pkg::ADDR_CTRL: begin
				rd_mux[mmcd_pkg::CTRL_RPLY_BIT] = rply_vld_r;
				rd_mux[mmcd_pkg::STAT_BUSY_BIT] = busy;
				rd_mux[mmcd_pkg::STAT_HOME_BIT] = home_r;
				rd_mux[mmcd_pkg::STAT_ADDR_LSB +: 8] = mod_addr_r;
			end
			mmcd_pkg::ADDR_RPLY_HDR:
				rd_mux = {mmcd_pkg::HOST_ADDR, mod_addr_r, rply_stat_r, rply_ins_r};
			mmcd_pkg::ADDR_RPLY_VAL: rd_mux = rply_val_r;
			mmcd_pkg::ADDR_RPLY_CSUM: rd_mux = {24'h000000, rply_sum};
			default: rd_err = 1'b1;
		endcase
	end

	// apb slave: one wait state, answer registered
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h00000000;
		end else if (ce) begin
			pready_r <= psel && penable && !pready_r;
			if (psel && penable && !pready_r) begin
				pslverr_r <= rd_err;
				prdata_r  <= pwrite ? 32'h00000000 : rd_mux;
			end
		end
	end

	// writes land on the edge that completes the access
	assign wr_fire     = ce && psel && penable && pready_r && pwrite && !pslverr_r;
	assign fr.byte_vld = wr_fire && paddr == mmcd_pkg::ADDR_RXDATA;
	assign fr.byte_dat = pwdata[7:0];
	assign fr.resync   = wr_fire && paddr == mmcd_pkg::ADDR_CTRL
		&& pwdata[mmcd_pkg::CTRL_RESYNC_BIT];
	assign fr.my_addr  = mod_addr_r;

	assign prdata    = prdata_r;
	assign pready    = pready_r;
	assign pslverr   = pslverr_r;
	assign home_busy = home_r;
	assign gp_out    = gp_out_r;
	assign nvm_req   = nvm_req_r;
	assign nvm_we    = nvm_we_r;
	assign nvm_addr  = nvm_addr_r;
	assign nvm_wdata = nvm_wdata_r;

	read_accum_a: assert property (@(posedge clk) disable iff (!rst_n)
		exec && fr.instr == mmcd_pkg::INS_READ_GLOBAL_PARAM && ok
		|=> accum_r == rply_val_r && rply_stat_r == mmcd_pkg::STAT_OK && rply_vld_r)
		else $error("read global param reply wrong");
	store_commit_a: assert property (@(posedge clk) disable iff (!rst_n)
		exec && fr.instr == mmcd_pkg::INS_STORE_GLOBAL_PARAM && fr.bank == mmcd_pkg::BANK_USER
		|=> nvm_req_r && nvm_we_r && nvm_wdata_r == $past(uvar_r[fr.typ]))
		else $error("store did not write nvm");
	auto_commit_a: assert property (@(posedge clk) disable iff (!rst_n)
		exec && fr.instr == mmcd_pkg::INS_WRITE_GLOBAL_PARAM && ok
		&& fr.bank == mmcd_pkg::BANK_MODULE |=> nvm_req_r && nvm_we_r
		&& nvm_addr_r == {mmcd_pkg::NVM_SEL_MOD, mmcd_pkg::PARAM_MOD_ADDR}
		&& nvm_wdata_r == $past(fr.value))
		else $error("bank 0 change not committed");
	boot_reload_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == mmcd_pkg::ST_BOOT |-> !rply_vld_r && !nvm_we_r)
		else $error("activity before user variable reload");
	restore_val_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && state_r == mmcd_pkg::ST_NVM && nvm_done
		&& pend_ins_r == mmcd_pkg::INS_RESTORE_GLOBAL_PRM
		|=> uvar_r[pend_idx_r] == $past(nvm_rdata) && rply_stat_r == mmcd_pkg::STAT_OK)
		else $error("restore did not reload variable");
	home_status_a: assert property (@(posedge clk) disable iff (!rst_n)
		exec && fr.instr == mmcd_pkg::INS_HOME_SEARCH && fr.typ == mmcd_pkg::HS_STATUS && ok
		|=> (rply_val_r != 32'h00000000) == $past(home_r))
		else $error("home status value wrong");
	home_start_a: assert property (@(posedge clk) disable iff (!rst_n)
		exec && fr.instr == mmcd_pkg::INS_HOME_SEARCH && fr.typ == mmcd_pkg::HS_START && ok
		|=> home_r && rply_stat_r == mmcd_pkg::STAT_OK)
		else $error("home search not started");
	set_output_a: assert property (@(posedge clk) disable iff (!rst_n)
		exec && fr.instr == mmcd_pkg::INS_SET_OUTPUT && ok && fr.typ < mmcd_pkg::NUM_OUTS
		|=> gp_out_r[$past(fr.typ[0])] == $past(fr.value[0]))
		else $error("output line not driven");
	bad_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
		exec && !ok |=> rply_stat_r != mmcd_pkg::STAT_OK && $stable(gp_out_r)
		&& !(home_r && !$past(home_r)) && $stable(accum_r) && state_r == mmcd_pkg::ST_IDLE)
		else $error("bad command changed state");
endmodule

// *** rtl/mmcd_pkg.sv ***
// constants and types shared by the motion command decoder files
package mmcd_pkg;
	// instruction codes
	localparam logic [7:0] INS_WRITE_GLOBAL_PARAM = 8'h09;
	localparam logic [7:0] INS_READ_GLOBAL_PARAM  = 8'h0a;
	localparam logic [7:0] INS_STORE_GLOBAL_PARAM = 8'h0b;
	localparam logic [7:0] INS_RESTORE_GLOBAL_PRM = 8'h0c;
	localparam logic [7:0] INS_HOME_SEARCH        = 8'h0d;
	localparam logic [7:0] INS_SET_OUTPUT         = 8'h0e;
	// banks of global parameters
	localparam logic [7:0] BANK_MODULE = 8'h00;
	localparam logic [7:0] BANK_USER   = 8'h02;
	localparam logic [7:0] BANK_IRQ    = 8'h03;
	// home search sub-commands
	localparam logic [7:0] HS_START  = 8'h00;
	localparam logic [7:0] HS_STOP   = 8'h01;
	localparam logic [7:0] HS_STATUS = 8'h02;
	// reply status codes
	localparam logic [7:0] STAT_OK    = 8'h64;
	localparam logic [7:0] ERR_INSTR  = 8'h02;
	localparam logic [7:0] ERR_TYPE   = 8'h03;
	localparam logic [7:0] ERR_VALUE  = 8'h04;
	// module settings and sizes
	localparam logic [7:0]  PARAM_MOD_ADDR = 8'h42;
	localparam logic [7:0]  MOD_ADDR_RST   = 8'h01;
	localparam logic [7:0]  HOST_ADDR      = 8'h02;
	localparam int          NUM_UVARS      = 256;
	localparam logic [7:0]  LAST_UVAR      = 8'hff;
	localparam logic [7:0]  NUM_IRQCFG     = 8'h08;
	localparam logic [7:0]  NUM_OUTS       = 8'h02;
	localparam logic [7:0]  SIO_ALL        = 8'hff;
	localparam logic [31:0] VAL_FROM_ACCUM = 32'hffffffff;
	localparam logic [31:0] SIO_ALL_MAX    = 32'h000000ff;
	localparam logic [3:0]  LAST_BODY_BYTE = 4'h8;
	// nonvolatile address: top bit selects the user variable area
	localparam int          NVM_AW       = 9;
	localparam logic        NVM_SEL_USER = 1'b1;
	localparam logic        NVM_SEL_MOD  = 1'b0;
	// register byte addresses
	localparam logic [7:0] ADDR_RXDATA    = 8'h00;
	localparam logic [7:0] ADDR_CTRL      = 8'h04;
	localparam logic [7:0] ADDR_RPLY_HDR  = 8'h08;
	localparam logic [7:0] ADDR_RPLY_VAL  = 8'h0c;
	localparam logic [7:0] ADDR_RPLY_CSUM = 8'h10;
	// control / status bit positions
	localparam int CTRL_RPLY_BIT   = 0;
	localparam int CTRL_RESYNC_BIT = 1;
	localparam int STAT_BUSY_BIT   = 1;
	localparam int STAT_HOME_BIT   = 2;
	localparam int STAT_ADDR_LSB   = 16;
	// decoder states, one-hot
	typedef enum logic [2:0] {
		ST_BOOT = 3'b001,
		ST_IDLE = 3'b010,
		ST_NVM  = 3'b100
	} mmcd_state_e;
endpackage

// *** rtl/mmcd_frame_if.sv ***
// byte stream into the frame assembler and decoded frame out of it
`timescale 1ns/1ps
interface mmcd_frame_if;
	logic        byte_vld;
	logic [7:0]  byte_dat;
	logic        resync;
	logic [7:0]  my_addr;
	logic        frm_vld;
	logic [7:0]  instr;
	logic [7:0]  typ;
	logic [7:0]  bank;
	logic [31:0] value;
	modport rx (input byte_vld, byte_dat, resync, my_addr,
		output frm_vld, instr, typ, bank, value);
	modport dec (output byte_vld, byte_dat, resync, my_addr,
		input frm_vld, instr, typ, bank, value);
endinterface

// *** rtl/mmcd_frame_rx.sv ***
// frame assembler: nine bytes, checksum and address filter
`timescale 1ns/1ps
module mmcd_frame_rx (
	input  wire logic clk,   // system clock
	input  wire logic rst_n, // sync reset, active low
	input  wire logic ce,    // clock enable
	mmcd_frame_if.rx  fr     // byte stream in, frame out
);
	logic [3:0] cnt_r;
	logic [7:0] sum_r;
	logic [7:0] buf_r [8];
	logic       frm_vld_r;

	// collect bytes; a bad sum or foreign address drops the frame silently
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_r     <= 4'h0;
			sum_r     <= 8'h00;
			frm_vld_r <= 1'b0;
		end else if (ce) begin
			frm_vld_r <= 1'b0;
			if (fr.resync) begin
				cnt_r <= 4'h0;
				sum_r <= 8'h00;
			end else if (fr.byte_vld) begin
				if (cnt_r == mmcd_pkg::LAST_BODY_BYTE) begin
					frm_vld_r <= (fr.byte_dat == sum_r) && (buf_r[0] == fr.my_addr);
					cnt_r     <= 4'h0;
					sum_r     <= 8'h00;
				end else begin
					buf_r[cnt_r[2:0]] <= fr.byte_dat;
					sum_r             <= 8'(sum_r + fr.byte_dat);
					cnt_r             <= 4'(cnt_r + 4'h1);
				end
			end
		end
	end

	// field positions in arrival order, value most significant first
	assign fr.frm_vld = frm_vld_r;
	assign fr.instr   = buf_r[1];
	assign fr.typ     = buf_r[2];
	assign fr.bank    = buf_r[3];
	assign fr.value   = {buf_r[4], buf_r[5], buf_r[6], buf_r[7]};

	frame_sum_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && fr.byte_vld && !fr.resync && cnt_r == mmcd_pkg::LAST_BODY_BYTE
		&& fr.byte_dat != sum_r |=> !frm_vld_r)
		else $error("frame with bad checksum accepted");
endmodule

// *** test/mmcd_nvm_model.sv ***
// nonvolatile word store standing behind the decoder's nvm port
`timescale 1ns/1ps
module mmcd_nvm_model (
	input  wire logic        clk,   // system clock
	input  wire logic        req,   // request, held until ack
	input  wire logic        we,    // write request
	input  wire logic [8:0]  addr,  // word address
	input  wire logic [31:0] wdata, // write data
	output logic      [31:0] rdata, // read data, valid with ack
	output logic             ack    // done, one cycle
);
	logic [31:0] mem [512];
	logic [1:0]  wait_r  = 2'h0;         // cycles waited on this request
	logic [8:0]  wr_addr = 9'h000;       // last written word, seen by the bench
	logic [31:0] wr_data = 32'h00000000; // last written data
	// preset contents give the boot reload a recognisable pattern
	initial begin
		ack = 1'b0;
		rdata = 32'h00000000;
		for (int i = 0; i < 512; i++) mem[i] = 32'h00c00000 | i;
	end
	// wait follows the low address bits so prompt and slow answers both occur
	always @(posedge clk) begin
		if (req && !ack && wait_r == addr[1:0]) begin
			ack <= 1'b1;
			wait_r <= 2'h0;
			rdata <= mem[addr];
			if (we) begin
				mem[addr] <= wdata;
				wr_addr <= addr;
				wr_data <= wdata;
			end
		end else begin
			ack <= 1'b0;
			rdata <= ~rdata; // no stale word outside ack
			wait_r <= (req && !ack) ? wait_r + 2'h1 : 2'h0;
		end
	end
endmodule

// *** test/motion_module_command_decoder_tb_top.sv ***
// self-checking bench for the motion command decoder
`timescale 1ns/1ps
module motion_module_command_decoder_tb_top;
	typedef struct packed {
		logic [7:0]  ins, ty, bk;
		logic [31:0] v;
		logic [7:0]  st;
		logic [1:0]  vm; // 0 ignore value, 1 exact, 2 nonzero
		logic [31:0] ev;
		logic [1:0]  gp;
		logic        hb;
	} mmcd_row_s;
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, ma = 8'h01;
	logic [31:0] pwdata = 32'h0, prdata, nvm_wdata, nvm_rdata, rq;
	logic        pready, pslverr, home_busy, nvm_req, nvm_we, nvm_ack, re;
	logic        home_sw = 1'b0;
	logic [1:0]  gp_out;
	logic [8:0]  nvm_addr;
	int          err_count = 0, n_checks = 0;
	mmcd_row_s rows [19] = '{
		'{8'h0a, 8'h42, 8'h00, 32'h0, 8'h64, 2'h1, 32'h1, 2'h0, 1'h0},
		'{8'h09, 8'h05, 8'h02, 32'h1234, 8'h64, 2'h0, 32'h0, 2'h0, 1'h0},
		'{8'h0b, 8'h05, 8'h02, 32'h0, 8'h64, 2'h0, 32'h0, 2'h0, 1'h0},
		'{8'h09, 8'h05, 8'h02, 32'h77, 8'h64, 2'h0, 32'h0, 2'h0, 1'h0},
		'{8'h0c, 8'h05, 8'h02, 32'h0, 8'h64, 2'h0, 32'h0, 2'h0, 1'h0},
		'{8'h0a, 8'h05, 8'h02, 32'h0, 8'h64, 2'h1, 32'h1234, 2'h0, 1'h0},
		'{8'h0a, 8'h09, 8'h02, 32'h0, 8'h64, 2'h1, 32'h00c00109, 2'h0, 1'h0},
		'{8'h0a, 8'h00, 8'h03, 32'h0, 8'h64, 2'h0, 32'h0, 2'h0, 1'h0},
		'{8'h0a, 8'h08, 8'h03, 32'h0, 8'h03, 2'h0, 32'h0, 2'h0, 1'h0},
		'{8'h0d, 8'h00, 8'h00, 32'h0, 8'h64, 2'h0, 32'h0, 2'h0, 1'h1},
		'{8'h0d, 8'h02, 8'h00, 32'h0, 8'h64, 2'h2, 32'h0, 2'h0, 1'h1},
		'{8'h0d, 8'h01, 8'h00, 32'h0, 8'h64, 2'h0, 32'h0, 2'h0, 1'h0},
		'{8'h0d, 8'h02, 8'h00, 32'h0, 8'h64, 2'h1, 32'h0, 2'h0, 1'h0},
		'{8'h0e, 8'h00, 8'h02, 32'h1, 8'h64, 2'h0, 32'h0, 2'h1, 1'h0},
		'{8'h0e, 8'h01, 8'h02, 32'h1, 8'h64, 2'h0, 32'h0, 2'h3, 1'h0},
		'{8'h0e, 8'hff, 8'h02, 32'h2, 8'h64, 2'h0, 32'h0, 2'h2, 1'h0},
		'{8'h30, 8'h00, 8'h00, 32'h0, 8'h02, 2'h0, 32'h0, 2'h2, 1'h0},
		'{8'h0e, 8'h00, 8'h02, 32'h2, 8'h04, 2'h0, 32'h0, 2'h2, 1'h0},
		'{8'h0d, 8'h00, 8'h01, 32'h0, 8'h03, 2'h0, 32'h0, 2'h2, 1'h0}
	};
	mmcd_top dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .home_sw(home_sw), .home_busy(home_busy), .gp_out(gp_out),
		.nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
		.nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack));
	mmcd_nvm_model store (.clk(clk), .req(nvm_req), .we(nvm_we), .addr(nvm_addr),
		.wdata(nvm_wdata), .rdata(nvm_rdata), .ack(nvm_ack));
	// 250 MHz clock
	always #2 clk = ~clk;
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_checks++;
		if (got !== ex) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// one apb transfer; held until pready is sampled, then one idle edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic frame(input logic [7:0] ad, ins, ty, bk, input logic [31:0] v,
			input logic [7:0] bad);
		logic [7:0] b [9];
		b = '{ad, ins, ty, bk, v[31:24], v[23:16], v[15:8], v[7:0], bad};
		for (int i = 0; i < 8; i++) b[8] += b[i];
		for (int i = 0; i < 9; i++) apb(1'b1, mmcd_pkg::ADDR_RXDATA, {24'h0, b[i]});
	endtask
	task automatic cmd(input mmcd_row_s r);
		logic [31:0] e;
		logic [7:0]  s;
		frame(ma, r.ins, r.ty, r.bk, r.v, 8'h00);
		// a module address change shows up in its own reply already
		if (r.ins == 8'h09 && r.bk == 8'h00 && r.ty == 8'h42) ma = r.v[7:0];
		do apb(1'b0, mmcd_pkg::ADDR_CTRL, 32'h0); while (rq[0] !== 1'b1);
		apb(1'b0, mmcd_pkg::ADDR_RPLY_HDR, 32'h0);
		e = {8'h02, ma, r.st, r.ins};
		chk("reply_hdr", e, rq);
		apb(1'b0, mmcd_pkg::ADDR_RPLY_VAL, 32'h0);
		if (r.vm == 2'h1) chk("reply_val", r.ev, rq);
		if (r.vm == 2'h2) chk("reply_active", 32'h1, {31'h0, rq != 32'h0});
		s = 8'(e[31:24] + e[23:16] + e[15:8] + e[7:0] + rq[31:24]
			+ rq[23:16] + rq[15:8] + rq[7:0]);
		apb(1'b0, mmcd_pkg::ADDR_RPLY_CSUM, 32'h0);
		chk("reply_sum", {24'h0, s}, rq);
		apb(1'b1, mmcd_pkg::ADDR_CTRL, 32'h1);
		chk("gp_out", {30'h0, r.gp}, {30'h0, gp_out});
		chk("home_busy", {31'h0, r.hb}, {31'h0, home_busy});
	endtask
	// a dropped frame must leave no reply behind
	task automatic no_reply(input logic [7:0] ad, input logic [7:0] bad);
		frame(ad, 8'h0a, 8'h42, 8'h00, 32'h0, bad);
		repeat (8) @(posedge clk);
		apb(1'b0, mmcd_pkg::ADDR_CTRL, 32'h0);
		chk("reply_valid", 32'h0, {31'h0, rq[0]});
		$display("test dropped frame done");
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// watchdog: boot reload plus all tests take well under this
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		end_sim();
	end
	initial begin
		repeat (16) @(posedge clk);
		chk("reset_outs", 32'h0, {27'h0, pready, pslverr, home_busy, gp_out});
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk("boot_req", 32'h1, {31'h0, nvm_req});
		do apb(1'b0, mmcd_pkg::ADDR_CTRL, 32'h0); while (rq[1] !== 1'b0);
		$display("test reset and boot done");
		foreach (rows[i]) begin
			cmd(rows[i]);
			$display("test row %0d done", i);
		end
		no_reply(8'h01, 8'h01);
		no_reply(8'h07, 8'h00);
		// a stray byte then a resync must not shift the next frame
		apb(1'b1, mmcd_pkg::ADDR_RXDATA, 32'h01);
		apb(1'b1, mmcd_pkg::ADDR_CTRL, 32'h2);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, re});
		cmd('{8'h0d, 8'h00, 8'h00, 32'h0, 8'h64, 2'h0, 32'h0, 2'h2, 1'h1});
		home_sw <= 1'b1;
		repeat (8) @(posedge clk);
		chk("home_end", 32'h0, {31'h0, home_busy});
		home_sw <= 1'b0;
		$display("test home switch done");
		cmd('{8'h09, 8'h42, 8'h00, 32'h3, 8'h64, 2'h0, 32'h0, 2'h2, 1'h0});
		chk("commit_addr", 32'h042, {23'h0, store.wr_addr});
		chk("commit_data", 32'h3, store.wr_data);
		ma = 8'h03;
		cmd('{8'h0a, 8'h42, 8'h00, 32'h0, 8'h64, 2'h1, 32'h3, 2'h2, 1'h0});
		// accumulator now holds 3 from the read above
		cmd('{8'h0e, 8'hff, 8'h02, 32'hffffffff, 8'h64, 2'h0, 32'h0, 2'h3, 1'h0});
		$display("test address change done");
		// second reset: frames refused during reload, stored variable comes back
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(1'b1, mmcd_pkg::ADDR_RXDATA, 32'h01);
		chk("busy_refuse", 32'h1, {31'h0, re});
		do apb(1'b0, mmcd_pkg::ADDR_CTRL, 32'h0); while (rq[1] !== 1'b0);
		ma = mmcd_pkg::MOD_ADDR_RST;
		cmd('{8'h0a, 8'h05, 8'h02, 32'h0, 8'h64, 2'h1, 32'h1234, 2'h0, 1'h0});
		$display("test second reset done");
		end_sim();
	end
endmodule
